// File: src/mdm_master.sv
// management master: register port, MDC divider, frame shifter, interrupt
// assumes external logic resolves the MDIO wire from o_pin.mdio_oe
`timescale 1ns/10ps

// What this block does
// R1 - enable bit 0 keeps the master idle and the MDIO line undriven
// R2 - MDC is derived from the system clock by the six-bit divider
// R3 - five-bit port address from config word 1 goes into each frame
// R4 - five-bit device address from config word 1 goes into each frame
// R5 - two-bit transaction kind picks the frame opcode
// R6 - writing initiate while ready starts a frame; initiate self-clears after
// R7 - ready reads 0 during a transaction, 1 otherwise, resets to 1
// R8 - low sixteen bits of write data feed the frame data field
// R9 - read data register holds captured bits, bit 16 mirrors ready
// R10 - completion with enable raises the interrupt, read data already valid
// R11 - interrupt never self-clears; no new frame while it is set
// R12 - bit 0 of every interrupt register is completion, rest reserved
// R13 - status bit records completion, write 0 clears, resets zero
// R14 - pending reads enable and status; write 1 clears
// R15 - enable register write 1 enables, resets zero
// R16 - acknowledge register write 1 clears the interrupt
// R17 - frame: 32 ones, start, opcode, addresses, turnaround, 16 data bits
// R18 - initiate while busy or disabled is ignored
module mdm_master (
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire mdm_pkg::mdm_bus_t i_bus,
   output logic [31:0] o_rdata,
   input wire logic i_mdio_i,
   output mdm_pkg::mdm_pin_t o_pin,
   output logic o_irq
);
   import mdm_pkg::*;

   typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_DONE} mdm_state_t;

   ////////////////////////////////////////////////////////////////////////
   logic enable_r;
   logic [5:0] div_r;
   logic [4:0] prt_r;
   logic [4:0] dev_r;
   logic [1:0] kind_r;
   logic [15:0] wdata_r;
   logic [15:0] rdata_r;
   logic flag_r;
   logic irq_en_r;
   logic [31:0] rdout_r;
   mdm_state_t state_r;
   logic [5:0] divcnt_r;
   logic mdc_r;
   logic [6:0] bitcnt_r;
   logic [63:0] shift_r;
   logic [2:0] sync_r;
   logic in_bit_r;
   logic mdio_o_r;
   logic mdio_oe_r;
   logic irq_r;

   wire wr_cfg0 = i_bus.wr && (i_bus.addr == OFS_CFG0);
   wire wr_cfg1 = i_bus.wr && (i_bus.addr == OFS_CFG1);
   wire wr_wdata = i_bus.wr && (i_bus.addr == OFS_WDATA);
   wire wr_flag = i_bus.wr && (i_bus.addr == OFS_IRQ_FLAG);
   wire wr_pend = i_bus.wr && (i_bus.addr == OFS_IRQ_PEND);
   wire wr_en = i_bus.wr && (i_bus.addr == OFS_IRQ_EN);
   wire wr_ack = i_bus.wr && (i_bus.addr == OFS_IRQ_ACK);
   wire ready = (state_r == ST_IDLE);
   // start only when enabled, idle and no completion still flagged
   wire start = wr_cfg1 && i_bus.wdata[BIT_INIT] && ready && enable_r
                && !flag_r; // see R6, R11, R18
   wire is_read = kind_r[1]; // see R5
   // mdc edges: rise and fall alternate, each at terminal count
   wire div_tc = (divcnt_r >= div_r);
   wire mdc_fall = div_tc && mdc_r;
   wire mdc_rise = div_tc && !mdc_r;
   wire frame_end = mdc_fall && (bitcnt_r == 7'(FRAME_BITS - 1));
   wire done = (state_r == ST_DONE);
   wire drive_bit = (bitcnt_r < 7'(TA_FIRST)) || !is_read;
   wire flag_clr = (wr_flag && !i_bus.wdata[0])
                   || (wr_pend && i_bus.wdata[0])
                   || (wr_ack && i_bus.wdata[0]); // see R13, R14, R16
   wire flag_nxt = done || (flag_r && !flag_clr); // see R13
   wire pend = flag_r && irq_en_r; // see R14, R12

   ////////////////////////////////////////////////////////////////////////
   // frame image, sent msb first
   // fields come from the initiating write itself: the registers only
   // take them at the same edge, so they would still hold the old frame
   wire [4:0] prt_sel = i_bus.wdata[PRT_LSB +: 5]; // see R3
   wire [4:0] dev_sel = i_bus.wdata[DEV_LSB +: 5]; // see R4
   wire [1:0] kind_sel = i_bus.wdata[KIND_LSB +: 2]; // see R5
   wire [63:0] frame = {{PREAMBLE_BITS{1'b1}}, START_CODE, kind_sel,
                        prt_sel, dev_sel, TA_WRITE,
                        wdata_r}; // see R17, R8

   ////////////////////////////////////////////////////////////////////////
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (i_bus.addr)
         OFS_CFG0: rd_mux = {25'h000_0000, enable_r, div_r};
         OFS_CFG1: rd_mux = {3'h0, prt_r, 3'h0, dev_r, kind_r, 2'h0,
                             !ready, 3'h0, ready, 7'h00}; // see R6, R7
         OFS_WDATA: rd_mux = {16'h0000, wdata_r};
         OFS_RDATA: rd_mux = {15'h0000, ready, rdata_r}; // see R9
         OFS_IRQ_FLAG: rd_mux = {31'h0000_0000, flag_r};
         OFS_IRQ_PEND: rd_mux = {31'h0000_0000, pend};
         OFS_IRQ_EN: rd_mux = {31'h0000_0000, irq_en_r};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         enable_r <= 1'b0;
         div_r <= RST_DIV;
         prt_r <= 5'h00;
         dev_r <= 5'h00;
         kind_r <= 2'h0;
         wdata_r <= 16'h0000;
         irq_en_r <= 1'b0;
         rdout_r <= 32'h0000_0000;
      end else begin
         if (wr_cfg0) begin
            enable_r <= i_bus.wdata[BIT_ENABLE];
            div_r <= i_bus.wdata[DIV_LSB +: 6];
         end
         if (wr_cfg1 && ready) begin
            prt_r <= i_bus.wdata[PRT_LSB +: 5];
            dev_r <= i_bus.wdata[DEV_LSB +: 5];
            kind_r <= i_bus.wdata[KIND_LSB +: 2];
         end
         if (wr_wdata && ready) begin
            wdata_r <= i_bus.wdata[15:0];
         end
         if (wr_en) begin
            irq_en_r <= i_bus.wdata[0]; // see R15
         end
         rdout_r <= i_bus.rd ? rd_mux : 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         sync_r <= 3'h0;
         in_bit_r <= 1'b0;
      end else begin
         sync_r <= {sync_r[1:0], i_mdio_i};
         if (sync_r[2] == sync_r[1]) begin
            in_bit_r <= sync_r[2];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         state_r <= ST_IDLE;
         divcnt_r <= 6'h00;
         mdc_r <= 1'b0;
         bitcnt_r <= 7'h00;
         shift_r <= 64'h0000_0000_0000_0000;
         rdata_r <= 16'h0000;
         mdio_o_r <= 1'b0;
         mdio_oe_r <= 1'b0;
      end else begin
         unique case (state_r)
            ST_IDLE: begin
               divcnt_r <= 6'h00;
               mdc_r <= 1'b0;
               mdio_oe_r <= 1'b0; // see R1
               if (start) begin
                  state_r <= ST_SHIFT;
                  bitcnt_r <= 7'h00;
                  shift_r <= frame;
                  mdio_o_r <= frame[63];
                  mdio_oe_r <= 1'b1;
               end
            end
            ST_SHIFT: begin
               divcnt_r <= div_tc ? 6'h00 : divcnt_r + 6'h01; // see R2
               if (div_tc) begin
                  mdc_r <= !mdc_r;
               end
               if (!enable_r) begin
                  state_r <= ST_DONE; // see R1
                  mdio_oe_r <= 1'b0;
               end else if (mdc_rise && is_read
                            && bitcnt_r >= 7'(FRAME_BITS - DATA_BITS)) begin
                  rdata_r <= {rdata_r[14:0], in_bit_r}; // see R9
               end
               if (enable_r && mdc_fall) begin
                  if (frame_end) begin
                     state_r <= ST_DONE;
                     mdio_oe_r <= 1'b0;
                  end else begin
                     bitcnt_r <= bitcnt_r + 7'h01;
                     shift_r <= {shift_r[62:0], 1'b0};
                     mdio_o_r <= shift_r[62];
                     mdio_oe_r <= (bitcnt_r + 7'h01 < 7'(TA_FIRST))
                                  || !is_read; // see R17
                  end
               end
            end
            ST_DONE: begin
               state_r <= ST_IDLE; // see R6, R7
               mdc_r <= 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         flag_r <= 1'b0;
         irq_r <= 1'b0;
      end else begin
         flag_r <= flag_nxt; // see R13, R11
         irq_r <= flag_nxt && (wr_en ? i_bus.wdata[0] : irq_en_r); // see R10
      end
   end

   assign o_rdata = rdout_r;
   assign o_irq = irq_r;
   assign o_pin.mdc = mdc_r;
   assign o_pin.mdio_o = mdio_o_r;
   assign o_pin.mdio_oe = mdio_oe_r;

   ////////////////////////////////////////////////////////////////////////
   property p_idle_quiet;
      @(posedge i_sys_clk) disable iff (i_rst)
         (!enable_r && ready) |=> !o_pin.mdio_oe;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet) // see R1
      else $error("mdio driven while disabled");

   property p_start_busy;
      @(posedge i_sys_clk) disable iff (i_rst)
         start |=> (state_r == ST_SHIFT) && o_pin.mdio_oe && o_pin.mdio_o;
   endproperty
   a_start_busy: assert property (p_start_busy) // see R6
      else $error("start did not begin a frame");

   property p_no_start_flag;
      @(posedge i_sys_clk) disable iff (i_rst)
         (ready && flag_r) |=> ready;
   endproperty
   a_no_start_flag: assert property (p_no_start_flag) // see R11
      else $error("frame began while completion flagged");

   property p_ignore_busy;
      @(posedge i_sys_clk) disable iff (i_rst)
         (state_r == ST_SHIFT && wr_cfg1) |=> $stable(prt_r) && $stable(kind_r);
   endproperty
   a_ignore_busy: assert property (p_ignore_busy) // see R18
      else $error("config changed during frame");

   property p_mdc_period;
      @(posedge i_sys_clk) disable iff (i_rst)
         (state_r == ST_SHIFT && div_r == 6'h04 && enable_r && mdc_rise)
         |=> !div_tc [*4] ##1 div_tc;
   endproperty
   a_mdc_period: assert property (p_mdc_period) // see R2
      else $error("mdc half period wrong");

   property p_done_flag;
      @(posedge i_sys_clk) disable iff (i_rst)
         done |=> flag_r && ready;
   endproperty
   a_done_flag: assert property (p_done_flag) // see R13
      else $error("completion not recorded");

   property p_irq_pend;
      @(posedge i_sys_clk) disable iff (i_rst)
         (pend && !flag_clr && !wr_en) |=> o_irq;
   endproperty
   a_irq_pend: assert property (p_irq_pend) // see R10
      else $error("interrupt not raised");

   property p_ack_clear;
      @(posedge i_sys_clk) disable iff (i_rst)
         (wr_ack && i_bus.wdata[0] && !done) |=> !flag_r && !o_irq;
   endproperty
   a_ack_clear: assert property (p_ack_clear) // see R16
      else $error("acknowledge did not clear");

   property p_read_ready;
      @(posedge i_sys_clk) disable iff (i_rst)
         (i_bus.rd && i_bus.addr == OFS_RDATA)
         |=> o_rdata[BIT_RD_READY] == $past(ready);
   endproperty
   a_read_ready: assert property (p_read_ready) // see R9
      else $error("read data ready bit wrong");

   property p_rdata_idle;
      @(posedge i_sys_clk) disable iff (i_rst)
         !i_bus.rd |=> (o_rdata == 32'h0000_0000);
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) // see R9
      else $error("read data not zero outside a read");

   property p_reset_state;
      @(posedge i_sys_clk)
         i_rst |=> ready && !o_irq && !o_pin.mdc && !o_pin.mdio_oe;
   endproperty
   a_reset_state: assert property (p_reset_state) // see R7
      else $error("reset state wrong");

   property p_flag_hold;
      @(posedge i_sys_clk) disable iff (i_rst)
         (flag_r && !flag_clr) |=> flag_r;
   endproperty
   a_flag_hold: assert property (p_flag_hold) // see R11
      else $error("completion flag cleared by itself");

   property p_flag_wr0;
      @(posedge i_sys_clk) disable iff (i_rst)
         (wr_flag && !i_bus.wdata[0] && !done) |=> !flag_r;
   endproperty
   a_flag_wr0: assert property (p_flag_wr0) // see R13
      else $error("status write 0 did not clear");

   property p_pend_clear;
      @(posedge i_sys_clk) disable iff (i_rst)
         (wr_pend && i_bus.wdata[0] && !done) |=> !flag_r;
   endproperty
   a_pend_clear: assert property (p_pend_clear) // see R14
      else $error("pending write 1 did not clear");

   property p_en_write;
      @(posedge i_sys_clk) disable iff (i_rst)
         wr_en |=> (irq_en_r == $past(i_bus.wdata[0]));
   endproperty
   a_en_write: assert property (p_en_write) // see R15
      else $error("enable write not taken");

   property p_irq_off;
      @(posedge i_sys_clk) disable iff (i_rst)
         (!irq_en_r && !wr_en) |=> !o_irq;
   endproperty
   a_irq_off: assert property (p_irq_off) // see R15, R10
      else $error("interrupt raised while disabled");

   property p_abort;
      @(posedge i_sys_clk) disable iff (i_rst)
         (state_r == ST_SHIFT && !enable_r)
         |=> (state_r == ST_DONE) && !o_pin.mdio_oe;
   endproperty
   a_abort: assert property (p_abort) // see R1
      else $error("frame not cut when disabled");

   property p_read_release;
      @(posedge i_sys_clk) disable iff (i_rst)
         (state_r == ST_SHIFT && is_read && bitcnt_r >= 7'(TA_FIRST))
         |-> !o_pin.mdio_oe;
   endproperty
   a_read_release: assert property (p_read_release) // see R17
      else $error("mdio driven during read data");

   property p_mdc_idle;
      @(posedge i_sys_clk) disable iff (i_rst)
         ready |-> !o_pin.mdc;
   endproperty
   a_mdc_idle: assert property (p_mdc_idle) // see R2
      else $error("mdc not low while idle");

   property p_bitcnt_max;
      @(posedge i_sys_clk) disable iff (i_rst)
         (state_r == ST_SHIFT) |-> (bitcnt_r <= 7'(FRAME_BITS - 1));
   endproperty
   a_bitcnt_max: assert property (p_bitcnt_max) // see R17
      else $error("bit counter past frame end");

   property p_cfg_write;
      @(posedge i_sys_clk) disable iff (i_rst)
         (wr_cfg1 && ready) |=> (prt_r == $past(i_bus.wdata[28:24]))
                                && (dev_r == $past(i_bus.wdata[20:16]));
   endproperty
   a_cfg_write: assert property (p_cfg_write) // see R3, R4
      else $error("addresses not taken while ready");

   property p_wdata_hold;
      @(posedge i_sys_clk) disable iff (i_rst)
         (wr_wdata && !ready) |=> $stable(wdata_r);
   endproperty
   a_wdata_hold: assert property (p_wdata_hold) // see R18, R8
      else $error("write data changed during frame");
endmodule

// File: src/mdm_pkg.sv
// package for the management-interface master: offsets, fields, resets
// assumes a 32-bit register port with byte addresses
package mdm_pkg;
   localparam logic [11:0] OFS_CFG0 = 12'h0500;
   localparam logic [11:0] OFS_CFG1 = 12'h0504;
   localparam logic [11:0] OFS_WDATA = 12'h0508;
   localparam logic [11:0] OFS_RDATA = 12'h050c;
   localparam logic [11:0] OFS_IRQ_FLAG = 12'h0600;
   localparam logic [11:0] OFS_IRQ_PEND = 12'h0610;
   localparam logic [11:0] OFS_IRQ_EN = 12'h0620;
   localparam logic [11:0] OFS_IRQ_ACK = 12'h0630;
   localparam int BIT_ENABLE = 6;
   localparam int DIV_LSB = 0;
   localparam int PRT_LSB = 24;
   localparam int DEV_LSB = 16;
   localparam int KIND_LSB = 14;
   localparam int BIT_INIT = 11;
   localparam int BIT_READY = 7;
   localparam int BIT_RD_READY = 16;
   localparam logic RST_READY = 1'b1;
   localparam logic [5:0] RST_DIV = 6'h00;
   localparam int PREAMBLE_BITS = 32;
   localparam int FRAME_BITS = 64;
   localparam int DATA_BITS = 16;
   // clause 45 turnaround starts at bit 46; data occupies bits 48..63
   localparam int TA_FIRST = 46;
   localparam logic [1:0] START_CODE = 2'b00;
   localparam logic [1:0] KIND_READ = 2'b11;
   localparam logic [1:0] KIND_READ_INC = 2'b10;
   localparam logic [1:0] TA_WRITE = 2'b10;

   typedef struct packed {
      logic [11:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } mdm_bus_t;

   typedef struct packed {
      logic mdc;
      logic mdio_o;
      logic mdio_oe;
   } mdm_pin_t;
endpackage

// File: verif/mdio_master_with_irq_test.sv
// bench for the management master: register port, frames, interrupt
// assumes the wire idles high through a pull-up when nobody drives it
`timescale 1ns/10ps
module mdio_master_with_irq_test;
   import mdm_pkg::*;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic arm = 1'b0;
   mdm_bus_t bus = '0;
   mdm_pin_t pin;
   logic [31:0] rdata;
   logic [31:0] got;
   logic [31:0] c;
   logic irq;
   logic drv;
   logic d;
   logic mdio;
   logic mdc_q = 1'b0;
   logic [63:0] frame;
   logic [63:0] fe;
   logic [15:0] phy_data = 16'h3c5a;
   int miscompares = 0;
   int n_tests = 0;
   int cyc = 0;
   int last = 0;
   int per = 0;
   logic [11:0] ra [9] = '{OFS_CFG0, OFS_CFG1, OFS_WDATA, OFS_RDATA,
      OFS_IRQ_FLAG, OFS_IRQ_PEND, OFS_IRQ_EN, OFS_IRQ_ACK, 12'h0700};
   logic [31:0] re [9] = '{32'h0000_0000, 32'h0000_0080, 32'h0000_0000,
      32'h0001_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
      32'h0000_0000, 32'h0000_0000};
   logic [1:0] kd [4] = '{2'b01, 2'b11, 2'b00, 2'b10};
   logic [11:0] ca [4] = '{OFS_IRQ_ACK, OFS_IRQ_PEND, OFS_IRQ_FLAG,
      OFS_IRQ_ACK};
   logic [31:0] cv [4] = '{32'h0000_0001, 32'h0000_0001, 32'h0000_0000,
      32'h0000_0001};

   assign mdio = pin.mdio_oe ? pin.mdio_o : (drv ? d : 1'b1);

   mdm_master i_dut (
      .i_sys_clk(sys_clk),
      .i_rst(rst),
      .i_bus(bus),
      .o_rdata(rdata),
      .i_mdio_i(mdio),
      .o_pin(pin),
      .o_irq(irq)
   );
   mdm_phy i_phy (
      .i_mdc(pin.mdc),
      .i_mdio(mdio),
      .i_arm(arm),
      .i_rdata(phy_data),
      .o_frame(frame),
      .o_drv(drv),
      .o_d(d)
   );

   initial begin
      forever #4 sys_clk = ~sys_clk;
   end
   ////////////////////////////////////////////////////////////////////////
   task final_report;
      if (miscompares == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task wr(input logic [11:0] a, input logic [31:0] v);
      @(posedge sys_clk);
      bus.addr <= a;
      bus.wdata <= v;
      bus.wr <= 1'b1;
      @(posedge sys_clk);
      bus.wr <= 1'b0;
   endtask
   task rd(input logic [11:0] a);
      @(posedge sys_clk);
      bus.addr <= a;
      bus.rd <= 1'b1;
      @(posedge sys_clk);
      bus.rd <= 1'b0;
      #1 got = rdata;
   endtask
   // link clock period and a hang limit
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      mdc_q <= pin.mdc;
      if (pin.mdc && !mdc_q) begin
         per <= cyc - last;
         last <= cyc;
      end
      if (cyc == 20000) begin
         miscompares++;
         final_report;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      for (int i = 0; i < 9; i++) begin
         rd(ra[i]);
         chk("reset value", re[i], got);
      end
      wr(OFS_CFG1, 32'h0000_0800);
      repeat (40) @(posedge sys_clk);
      rd(OFS_CFG1);
      chk("start while off", 32'h0000_0080, got);
      chk("oe while off", 32'h0, {31'h0, pin.mdio_oe});
      wr(OFS_CFG0, 32'h0000_0044);
      wr(OFS_IRQ_EN, 32'h0000_0001);
      wr(OFS_WDATA, 32'h0000_a5c3);
      for (int k = 0; k < 4; k++) begin
         c = {3'h0, 5'h15, 3'h0, 5'h0a, kd[k], 2'h0, 1'b1, 11'h000};
         fe = {32'hffff_ffff, START_CODE, kd[k], 5'h15, 5'h0a, TA_WRITE,
            kd[k][1] ? phy_data : 16'ha5c3};
         @(posedge sys_clk);
         arm <= 1'b1;
         @(posedge sys_clk);
         arm <= 1'b0;
         wr(OFS_CFG1, c);
         rd(OFS_CFG1);
         chk("busy word", c, got);
         for (int i = 0; i < 1000 && got[BIT_READY] !== 1'b1; i++) rd(OFS_CFG1);
         chk("done word", c ^ 32'h0000_0880, got);
         chk("frame head", fe[63:32], frame[63:32]);
         chk("frame tail", fe[31:0], frame[31:0]);
         chk("irq up", 32'h1, {31'h0, irq});
         rd(OFS_RDATA);
         if (kd[k][1]) chk("read data", {16'h0001, phy_data}, got);
         rd(OFS_IRQ_PEND);
         chk("pending", 32'h1, got);
         if (k == 0) begin
            wr(OFS_CFG1, c);
            repeat (40) @(posedge sys_clk);
            rd(OFS_CFG1);
            chk("start while irq", c ^ 32'h0000_0880, got);
         end
         wr(ca[k], cv[k]);
         @(posedge sys_clk);
         #1 chk("irq cleared", 32'h0, {31'h0, irq});
         rd(OFS_IRQ_FLAG);
         chk("status cleared", 32'h0, got);
      end
      // interrupt disabled, then enable cleared mid-frame
      wr(OFS_IRQ_EN, 32'h0000_0000);
      c = {3'h0, 5'h15, 3'h0, 5'h0a, 2'b01, 2'h0, 1'b1, 11'h000};
      @(posedge sys_clk);
      arm <= 1'b1;
      @(posedge sys_clk);
      arm <= 1'b0;
      wr(OFS_CFG1, c);
      repeat (100) @(posedge sys_clk);
      @(negedge pin.mdc);
      wr(OFS_CFG0, 32'h0000_0004);
      repeat (4) @(posedge sys_clk);
      #1 chk("oe after abort", 32'h0, {31'h0, pin.mdio_oe});
      rd(OFS_CFG1);
      chk("ready after abort", c ^ 32'h0000_0880, got);
      rd(OFS_IRQ_FLAG);
      chk("status after abort", 32'h1, got);
      chk("irq while disabled", 32'h0, {31'h0, irq});
      rd(OFS_IRQ_PEND);
      chk("pending while disabled", 32'h0, got);
      chk("mdc period", 32'd10, per);
      final_report;
   end
endmodule

// File: verif/mdm_phy.sv
// far-side device model for the management link: shifts in every bit
// assumes the bench resolves the wire with a pull-up and pulses i_arm
`timescale 1ns/10ps
module mdm_phy (
   input wire logic i_mdc,
   input wire logic i_mdio,
   input wire logic i_arm,
   input wire logic [15:0] i_rdata,
   output logic [63:0] o_frame,
   output logic o_drv,
   output logic o_d
);
   int n = 0;
   logic rd_q = 1'b0;
   initial begin
      o_frame = '0;
      o_drv = 1'b0;
      o_d = 1'b0;
   end
   // bits taken on the rising edge of the link clock
   always @(posedge i_mdc or posedge i_arm) begin
      if (i_arm) begin
         n <= 0;
      end else begin
         o_frame <= {o_frame[62:0], i_mdio};
         n <= n + 1;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // read frames: drive 0 in the second turnaround bit, then data msb first
   always @(negedge i_mdc) begin
      if (n == 46) begin
         rd_q <= o_frame[11];
      end
      o_drv <= rd_q && n >= 47 && n <= 63;
      o_d <= (n >= 48) ? i_rdata[63 - n] : 1'b0;
   end
endmodule
